/* rtl/dpd_dma_ctrl.sv */
/*
 Dual-priority event-driven DMA controller: event capture, encoder, two parameter
 memories, two 3-D address engines and the crossbar port muxing.
 Assumes classic Wishbone slaves on the crossbar ports and synchronous event inputs.
*/
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module dpd_dma_ctrl #(
    parameter int NEVT = dpd_pkg::NEVT,
    parameter int NXFR = dpd_pkg::NXFR
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Wishbone register slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Event sources
    input wire logic [NEVT-1:0] periph_evt_i,
    input wire logic [dpd_pkg::NAUD-1:0] audio_mute_input,
    input wire logic [dpd_pkg::NAUD-1:0] aud_tx_err_i,
    input wire logic [dpd_pkg::NAUD-1:0] aud_rx_err_i,
    // CPU interrupt requests, one pulse per group
    output logic [dpd_pkg::NGRP-1:0] cpu_irq_o,
    output logic [dpd_pkg::NGRP-1:0][4:0] cpu_irq_num_o,
    // Crossbar slave ports
    output dpd_pkg::dpd_xreq_t slv_req_o [dpd_pkg::NSLV],
    input wire logic [dpd_pkg::NSLV-1:0] slv_ack_i,
    input wire logic [dpd_pkg::NSLV-1:0][31:0] slv_dat_i,
    // Other crossbar master
    input wire dpd_pkg::dpd_xreq_t oth_req_i,
    output logic oth_ack_o,
    output logic [31:0] oth_dat_o
);
    import dpd_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    logic [31:0] pol_q, ena_q, grp_q, flag_q, trig_q, state_q, hist_q;
    logic [31:0] ev_raw, set_vec, take_all, ena_clr, wmask, rd_mux;
    logic [31:0] evt_mem [NGRP][NEVT];
    logic [31:0] xfr_mem [NGRP][NXFR][4];
    logic [31:0] take_vec [NGRP];
    logic [31:0] clr_vec [NGRP];
    logic [NGRP-1:0] busy;
    logic ack_q, wb_req, wb_wr;
    logic [1:0] rgn;
    logic [9:0] off;
    dpd_xreq_t mreq [NMST];
    logic [NMST-1:0] mcyc, mack;
    logic [NMST-1:0][2:0] msel;
    logic [NMST-1:0][31:0] mdat;
    logic [NSLV-1:0][NMST-1:0] grant;

    // Event vector
    always_comb
    begin
        ev_raw = periph_evt_i;
        ev_raw[EVT_TRIG_A] = trig_q[TRIG_BIT_A];
        ev_raw[EVT_TRIG_B] = trig_q[TRIG_BIT_B];
        ev_raw[EVT_AUD0+:NAUD] = audio_mute_input | aud_tx_err_i | aud_rx_err_i;
        ev_raw = ev_raw & EVT_LIVE;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= '0;
            hist_q <= '0;
        end
        else
        begin
            state_q <= ev_raw;
            hist_q <= state_q;
        end
    end

    // Polarity 1 catches rising edges, 0 falling edges
    assign set_vec = (pol_q & state_q & ~hist_q) | (~pol_q & ~state_q & hist_q);
    assign take_all = take_vec[0] | take_vec[1];
    assign ena_clr = clr_vec[0] | clr_vec[1];

    // Wishbone decode
    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_wr = wb_req && wb_we_i && ack_q;
    assign rgn = wb_adr_i[11:10];
    assign off = wb_adr_i[9:0];
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wb_ack_o = ack_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        return (old & ~m) | (nw & m);
    endfunction

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_q <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            ack_q <= wb_req && !ack_q;
            if (wb_req && !ack_q)
            begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    // A set in the same cycle as a clear wins, so no edge is lost
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag_q <= '0;
        end
        else if (wb_wr && rgn == RGN_REG && off == REG_FLAG)
        begin
            flag_q <= ((flag_q & ~(wb_dat_i & wmask) & ~take_all) | set_vec) & EVT_LIVE;
        end
        else
        begin
            flag_q <= ((flag_q & ~take_all) | set_vec) & EVT_LIVE;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pol_q <= '0;
            grp_q <= '0;
            trig_q <= '0;
        end
        else if (wb_wr && rgn == RGN_REG)
        begin
            if (off == REG_POL)
            begin
                pol_q <= merge(pol_q, wb_dat_i, wmask);
            end
            if (off == REG_GRP)
            begin
                grp_q <= merge(grp_q, wb_dat_i, wmask);
            end
            if (off == REG_TRIG)
            begin
                trig_q <= merge(trig_q, wb_dat_i, wmask);
            end
        end
    end

    // An engine finishing a one-shot entry disables its event after any bus write
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ena_q <= '0;
        end
        else if (wb_wr && rgn == RGN_REG && off == REG_ENA)
        begin
            ena_q <= merge(ena_q, wb_dat_i, wmask) & ~ena_clr;
        end
        else
        begin
            ena_q <= ena_q & ~ena_clr;
        end
    end

    // Parameter memories: event table below, transfer table above
    always_ff @(posedge clk)
    begin
        if (wb_wr && (rgn == RGN_HI || rgn == RGN_LO))
        begin
            if (!off[7])
            begin
                evt_mem[rgn-1][off[6:2]] <= merge(evt_mem[rgn-1][off[6:2]], wb_dat_i, wmask);
            end
            else
            begin
                xfr_mem[rgn-1][off[6:4]][off[3:2]] <=
                    merge(xfr_mem[rgn-1][off[6:4]][off[3:2]], wb_dat_i, wmask);
            end
        end
    end

    always_comb
    begin
        rd_mux = '0;
        if (rgn == RGN_REG)
        begin
            unique case (off)
                REG_POL: rd_mux = pol_q;
                REG_ENA: rd_mux = ena_q;
                REG_GRP: rd_mux = grp_q;
                REG_FLAG: rd_mux = flag_q;
                REG_STATE: rd_mux = state_q;
                REG_TRIG: rd_mux = trig_q;
                REG_STAT: rd_mux = {30'h0, busy};
                default: rd_mux = '0;
            endcase
        end
        else if (rgn == RGN_HI || rgn == RGN_LO)
        begin
            rd_mux = off[7] ? xfr_mem[rgn-1][off[6:4]][off[3:2]] : evt_mem[rgn-1][off[6:2]];
        end
    end

    // Address engines; group 0 serves the high group, group 1 the low group
    genvar g;
    generate
        for (g = 0; g < NGRP; g++)
        begin : g_eng
            dpd_state_t st_q;
            logic [4:0] ev_q;
            logic [31:0] sb_q, db_q, so_q, do_q, dat_q, lenb_q, step_q, ent, inc;
            logic [7:0] c0_q, c1_q, c2_q, n0_q, n1_q, n2_q, c0_d, c1_d, c2_d;
            logic [15:0] i1_q, i2_q;
            logic rel_q, last, fnd;
            logic [31:0] ready;
            logic [4:0] idx;
            logic [31:0] tw [4];

            // Lowest pending, enabled event of this group goes first
            always_comb
            begin
                ready = flag_q & ena_q & ((g == M_HI) ? grp_q : ~grp_q);
                fnd = 1'b0;
                idx = '0;
                for (int k = NEVT - 1; k >= 0; k--)
                begin
                    if (ready[k])
                    begin
                        fnd = 1'b1;
                        idx = 5'(k);
                    end
                end
            end
            assign take_vec[g] = (st_q == ST_IDLE && fnd) ? (32'h1 << idx) : '0;
            assign busy[g] = (st_q != ST_IDLE);
            assign ent = evt_mem[g][ev_q];
            assign tw = xfr_mem[g][ent[EE_PTR_LSB+:3]];
            assign clr_vec[g] = (st_q == ST_WR && mack[g] && last && !rel_q) ?
                                (32'h1 << ev_q) : '0;

            // 3-D stepping: element, then row index, then frame index
            always_comb
            begin
                last = 1'b0;
                inc = step_q;
                c0_d = c0_q + 8'h01;
                c1_d = c1_q;
                c2_d = c2_q;
                if (c0_q + 8'h01 >= n0_q)
                begin
                    c0_d = '0;
                    inc = {16'h0, i1_q};
                    c1_d = c1_q + 8'h01;
                    if (c1_q + 8'h01 >= n1_q)
                    begin
                        c1_d = '0;
                        inc = {16'h0, i2_q};
                        c2_d = c2_q + 8'h01;
                        last = (c2_q + 8'h01 >= n2_q);
                    end
                end
            end

            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    st_q <= ST_IDLE;
                    {ev_q, sb_q, db_q, so_q, do_q, dat_q, lenb_q, step_q} <= '0;
                    {c0_q, c1_q, c2_q, n0_q, n1_q, n2_q, i1_q, i2_q, rel_q} <= '0;
                    cpu_irq_o[g] <= 1'b0;
                    cpu_irq_num_o[g] <= '0;
                end
                else
                begin
                    cpu_irq_o[g] <= 1'b0;
                    unique case (st_q)
                        ST_IDLE:
                        begin
                            if (fnd)
                            begin
                                ev_q <= idx;
                                st_q <= ST_EVT;
                            end
                        end
                        ST_EVT:
                        begin
                            if (ent[EE_IRQ_TYPE])
                            begin
                                cpu_irq_o[g] <= 1'b1;
                                cpu_irq_num_o[g] <= ent[EE_IRQ_LSB+:5];
                                st_q <= ST_IDLE;
                            end
                            else
                            begin
                                sb_q <= tw[TW_SRC];
                                db_q <= tw[TW_DST];
                                {so_q, do_q, c0_q, c1_q, c2_q} <= '0;
                                n0_q <= tw[TW_CNT][CNT0_LSB+:8];
                                n1_q <= tw[TW_CNT][CNT1_LSB+:8];
                                n2_q <= tw[TW_CNT][CNT2_LSB+:8];
                                lenb_q <= {22'h0, tw[TW_CNT][CIRC_LSB+:8], 2'b00};
                                i1_q <= tw[TW_IDX][IDX1_LSB+:16];
                                i2_q <= tw[TW_IDX][IDX2_LSB+:16];
                                step_q <= 32'h1 << ent[EE_SIZE_LSB+:2];
                                rel_q <= ent[EE_RELOAD];
                                st_q <= ST_RD;
                            end
                        end
                        ST_RD:
                        begin
                            if (mack[g])
                            begin
                                dat_q <= mdat[g];
                                st_q <= ST_WR;
                            end
                        end
                        ST_WR:
                        begin
                            if (mack[g])
                            begin
                                so_q <= dpd_wrap(so_q, inc, lenb_q);
                                do_q <= dpd_wrap(do_q, inc, lenb_q);
                                {c0_q, c1_q, c2_q} <= {c0_d, c1_d, c2_d};
                                st_q <= last ? ST_IDLE : ST_RD;
                            end
                        end
                    endcase
                end
            end

            always_comb
            begin
                mreq[g].cyc = (st_q == ST_RD) || (st_q == ST_WR);
                mreq[g].we = (st_q == ST_WR);
                mreq[g].adr = (st_q == ST_WR) ? db_q + do_q : sb_q + so_q;
                mreq[g].dat = dat_q;
            end

            sequence s_irq_evt;
                st_q == ST_EVT && ent[EE_IRQ_TYPE];
            endsequence
            a_irq_raise: assert property (s_irq_evt |=> cpu_irq_o[g] ##1 !cpu_irq_o[g])
                else $error("interrupt entry did not pulse its interrupt once");
            a_group_route: assert property ((take_vec[g] & ~ena_q) == 0 &&
                                            (take_vec[g] & ((g == M_HI) ? ~grp_q : grp_q)) == 0)
                else $error("event taken by wrong group or while disabled");
            a_single_event: assert property (st_q != ST_IDLE |-> take_vec[g] == 0)
                else $error("engine accepted a second event while busy");
        end
    endgenerate

    // Crossbar: arbitration per slave port, requests steered by grant
    assign mreq[M_OTH] = oth_req_i;
    always_comb
    begin
        mack = '0;
        mdat = '0;
        for (int m = 0; m < NMST; m++)
        begin
            mcyc[m] = mreq[m].cyc;
            msel[m] = dpd_slave_of(mreq[m].adr);
            for (int s = 0; s < NSLV; s++)
            begin
                if (grant[s][m])
                begin
                    mack[m] = mack[m] | (slv_ack_i[s] && msel[m] == 3'(s));
                    // A port still granted from the last access must not leak its data
                    mdat[m] = mdat[m] | ((msel[m] == 3'(s)) ? slv_dat_i[s] : 32'h0);
                end
            end
        end
    end
    assign oth_ack_o = mack[M_OTH];
    assign oth_dat_o = mdat[M_OTH];

    genvar s;
    generate
        for (s = 0; s < NSLV; s++)
        begin : g_slv
            always_comb
            begin
                slv_req_o[s] = '0;
                for (int m = NMST - 1; m >= 0; m--)
                begin
                    if (grant[s][m])
                    begin
                        slv_req_o[s] = mreq[m];
                    end
                end
                // Grant lags one cycle; never show a master that already moved on
                slv_req_o[s].cyc = slv_req_o[s].cyc && (dpd_slave_of(slv_req_o[s].adr) == 3'(s));
            end
        end
    endgenerate

    dpd_xbar_arb #(.NSLV(NSLV), .NMST(NMST)) u_arb (
        .clk(clk),
        .reset_n(reset_n),
        .mst_cyc(mcyc),
        .mst_sel(msel),
        .grant(grant)
    );

    sequence s_trig_rise;
        ($rose(trig_q[TRIG_BIT_A]) && pol_q[EVT_TRIG_A]) ##1 pol_q[EVT_TRIG_A];
    endsequence
    a_trig_event: assert property (s_trig_rise |=> flag_q[EVT_TRIG_A])
        else $error("trigger bit edge did not raise event 0");
    a_state_mirror: assert property (state_q == $past(ev_raw))
        else $error("event state does not follow its input");
    a_flag_capture: assert property (|set_vec |=> (flag_q & $past(set_vec)) == $past(set_vec))
        else $error("selected edge not latched");
    a_flag_release: assert property ((|take_all) && (take_all & set_vec) == 0 && !wb_wr
                                     |=> (flag_q & $past(take_all)) == 0)
        else $error("accepted flag not cleared");
    a_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
endmodule // dpd_dma_ctrl

/* rtl/dpd_pkg.sv */
/*
 Shared constants, types and helpers of the dual-priority event-driven DMA controller.
 Assumes a single clock domain and 32-bit classic Wishbone register access.
*/
package dpd_pkg;
    localparam int NEVT = 32;
    localparam int NGRP = 2;
    localparam int NXFR = 8;
    localparam int NSLV = 5;
    localparam int NMST = 3;
    localparam int NAUD = 3;
    localparam int M_HI = 0;
    localparam int M_LO = 1;
    localparam int M_OTH = 2;
    // Event wiring
    localparam int TRIG_BIT_A = 0;
    localparam int TRIG_BIT_B = 16;
    localparam int EVT_TRIG_A = 0;
    localparam int EVT_TRIG_B = 1;
    localparam int EVT_AUD0 = 26;
    localparam logic [31:0] EVT_LIVE = 32'hfdff_ffff;
    // Register map, byte offsets in the low address bits
    localparam logic [1:0] RGN_REG = 2'h0;
    localparam logic [1:0] RGN_HI = 2'h1;
    localparam logic [1:0] RGN_LO = 2'h2;
    localparam logic [9:0] REG_POL = 10'h000;
    localparam logic [9:0] REG_ENA = 10'h004;
    localparam logic [9:0] REG_GRP = 10'h008;
    localparam logic [9:0] REG_FLAG = 10'h00c;
    localparam logic [9:0] REG_STATE = 10'h010;
    localparam logic [9:0] REG_TRIG = 10'h014;
    localparam logic [9:0] REG_STAT = 10'h018;
    // Event entry fields
    localparam int EE_IRQ_TYPE = 0;
    localparam int EE_SYNC = 1;
    localparam int EE_RELOAD = 2;
    localparam int EE_SIZE_LSB = 3;
    localparam int EE_PTR_LSB = 5;
    localparam int EE_IRQ_LSB = 8;
    // Transfer entry words and fields
    localparam logic [1:0] TW_SRC = 2'h0;
    localparam logic [1:0] TW_DST = 2'h1;
    localparam logic [1:0] TW_CNT = 2'h2;
    localparam logic [1:0] TW_IDX = 2'h3;
    localparam int CNT0_LSB = 0;
    localparam int CNT1_LSB = 8;
    localparam int CNT2_LSB = 16;
    localparam int CIRC_LSB = 24;
    localparam int IDX1_LSB = 0;
    localparam int IDX2_LSB = 16;
    // Crossbar slave select field of a master address
    localparam int XSEL_LSB = 28;

    typedef struct packed {
        logic cyc;
        logic we;
        logic [31:0] adr;
        logic [31:0] dat;
    } dpd_xreq_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_EVT = 4'b0010,
        ST_RD = 4'b0100,
        ST_WR = 4'b1000
    } dpd_state_t;

    function automatic logic [2:0] dpd_slave_of(input logic [31:0] adr);
        logic [2:0] s;
        s = adr[XSEL_LSB+:3];
        return (s > 3'(NSLV - 1)) ? 3'(NSLV - 1) : s;
    endfunction

    // Circular offset step; a zero length disables wrapping
    function automatic logic [31:0] dpd_wrap(input logic [31:0] off, input logic [31:0] inc,
                                             input logic [31:0] lenb);
        logic [31:0] s;
        s = off + inc;
        if ((lenb != 32'h0) && (s >= lenb))
        begin
            s = s - lenb;
        end
        return s;
    endfunction
endpackage

/* rtl/dpd_xbar_arb.sv */
/*
 Per-slave-port arbiter of the peripheral crossbar.
 Assumes master 0 is the high-priority engine, master 1 the low-priority engine.
*/
`timescale 1ns/1ps
module dpd_xbar_arb #(
    parameter int NSLV = dpd_pkg::NSLV,
    parameter int NMST = dpd_pkg::NMST
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Master requests
    input wire logic [NMST-1:0] mst_cyc,
    input wire logic [NMST-1:0][2:0] mst_sel,
    // Grants, one-hot per slave port
    output logic [NSLV-1:0][NMST-1:0] grant
);
    import dpd_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    genvar s;
    generate
        for (s = 0; s < NSLV; s++)
        begin : g_port
            logic [NMST-1:0] want;
            logic [NMST-1:0] pick;
            logic hold;
            always_comb
            begin
                want = '0;
                for (int m = 0; m < NMST; m++)
                begin
                    want[m] = mst_cyc[m] && (mst_sel[m] == 3'(s));
                end
                // Lowest index wins: high engine, then low engine, then the rest
                pick = want & (~want + 1'b1);
                hold = |(grant[s] & want);
            end
            // An owner keeps the port until it lets go, so a read/write pair is not split
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    grant[s] <= '0;
                end
                else if (!hold)
                begin
                    grant[s] <= pick;
                end
            end
            a_hi_first: assert property (want[0] && !hold |=> grant[s][0])
                else $error("high engine not granted first");
            a_lo_second: assert property (want[1] && !want[0] && !hold |=> grant[s][1])
                else $error("low engine not granted ahead of others");
        end
    endgenerate
endmodule // dpd_xbar_arb

/* tb/dpd_dma_ctrl_tb_top.sv */
/* Bench of the DMA controller: registers, capture, interrupt, transfer.
   Assumes the slave model on all crossbar ports. */
`timescale 1ns/1ps
module dpd_dma_ctrl_tb_top;
    import dpd_pkg::*;
    logic clk = 0, reset_n = 0, cyc = 0, we = 0, slow = 0, ack, oack;
    logic [31:0] adr = '0, wd = '0, q, rdat, pev = '0, odat;
    logic [2:0] mute = '0, txe = '0, rxe = '0;
    dpd_xreq_t oreq = '0;
    logic [1:0] irq;
    logic [1:0][4:0] irqn;
    dpd_xreq_t sreq [NSLV];
    logic [NSLV-1:0] sack;
    logic [NSLV-1:0][31:0] sdat;
    int n_mismatch = 0, comparisons = 0, n;
    always #10 clk = ~clk;
    dpd_dma_ctrl i_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat),
        .wb_ack_o(ack), .periph_evt_i(pev), .audio_mute_input(mute), .aud_tx_err_i(txe),
        .aud_rx_err_i(rxe), .cpu_irq_o(irq), .cpu_irq_num_o(irqn), .slv_req_o(sreq),
        .slv_ack_i(sack), .slv_dat_i(sdat), .oth_req_i(oreq), .oth_ack_o(oack),
        .oth_dat_o(odat));
    dpd_slave_model i_slv (.clk(clk), .slow(slow), .req(sreq), .ack(sack), .dat(sdat));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (ack !== 1'b1)
        begin
            n_mismatch++;
            $display("mismatch wb_ack expected 1 seen %b", ack);
        end
        q = rdat;
        cyc <= 1'b0;
        @(posedge clk);
    endtask
    task automatic oth(input logic w, input logic [31:0] a, input logic [31:0] d);
        n = 0;
        oreq <= {1'b1, w, a, d};
        @(posedge clk);
        while (oack !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (oack !== 1'b1)
        begin
            n_mismatch++;
            $display("mismatch oth_ack expected 1 seen %b", oack);
        end
        q = odat;
        oreq <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, '0);
        chk(nm, e, q);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_capture();
        rd(32'h004, 32'h0, "enable");
        wb(1'b1, 32'h01c, 32'hffff_ffff);
        rd(32'h01c, 32'h0, "unmapped");
        wb(1'b1, 32'h000, 32'h4);
        pev <= 32'h0200_000d;
        mute <= 3'h1;
        txe <= 3'h2;
        rxe <= 3'h4;
        repeat (4) @(posedge clk);
        rd(32'h010, 32'h1c00_000c, "state");
        rd(32'h00c, 32'h4, "flag rise");
        pev <= 32'h0;
        mute <= 3'h0;
        txe <= 3'h0;
        rxe <= 3'h0;
        repeat (4) @(posedge clk);
        rd(32'h00c, 32'h1c00_000c, "flag fall");
        wb(1'b1, 32'h00c, 32'hffff_ffff);
    endtask
    task automatic t_irq();
        wb(1'b1, 32'h410, 32'h1301);
        wb(1'b1, 32'h000, 32'h10);
        wb(1'b1, 32'h008, 32'h10);
        wb(1'b1, 32'h004, 32'h10);
        pev <= 32'h10;
        for (int k = 0; k < 10 && irq[0] !== 1'b1; k++)
            @(posedge clk);
        chk("irq high", 32'h1, {31'h0, irq[0]});
        chk("irq num", 32'h13, {27'h0, irqn[0]});
        chk("irq low", 32'h0, {31'h0, irq[1]});
        rd(32'h00c, 32'h0, "flag taken");
    endtask
    task automatic t_xfer();
        slow <= 1'b1;
        i_slv.mem[1][0] = 32'ha5a5_0001;
        i_slv.mem[1][1] = 32'h5a5a_0002;
        i_slv.mem[3][0] = 32'h3c3c_0003;
        wb(1'b1, 32'h800, 32'hf0);
        wb(1'b1, 32'h8f0, 32'h1000_0000);
        wb(1'b1, 32'h8f4, 32'h2000_0000);
        wb(1'b1, 32'h8f8, 32'h2);
        wb(1'b1, 32'h8fc, 32'h0);
        wb(1'b1, 32'h404, 32'h10);
        wb(1'b1, 32'h480, 32'h3000_0000);
        wb(1'b1, 32'h484, 32'h4000_0000);
        wb(1'b1, 32'h488, 32'h1);
        wb(1'b1, 32'h48c, 32'h0);
        wb(1'b1, 32'h000, 32'h3);
        wb(1'b1, 32'h008, 32'h12);
        wb(1'b1, 32'h004, 32'h13);
        wb(1'b1, 32'h014, 32'h0001_0001);
        repeat (40) @(posedge clk);
        rd(32'h018, 32'h0, "status");
        chk("copy 0", 32'ha5a5_0001, i_slv.mem[2][0]);
        chk("copy 1", 32'h5a5a_0002, i_slv.mem[2][1]);
        chk("copy high", 32'h3c3c_0003, i_slv.mem[4][0]);
        rd(32'h004, 32'h10, "enable after");
    endtask
    task automatic t_other();
        oth(1'b1, 32'h3000_0004, 32'h1234_5678);
        chk("other write", 32'h1234_5678, i_slv.mem[3][1]);
        oth(1'b0, 32'h3000_0004, 32'h0);
        chk("other read", 32'h1234_5678, q);
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_capture();
        t_irq();
        t_xfer();
        t_other();
        report_and_stop();
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule // dpd_dma_ctrl_tb_top

/* tb/dpd_slave_model.sv */
/* Crossbar slave memories, 16 words per port.
   Assumes one cyc per port, held until ack. */
`timescale 1ns/1ps
module dpd_slave_model
    import dpd_pkg::*;
(
    // Clock and pacing
    input wire logic clk,
    input wire logic slow,
    // Crossbar ports
    input wire dpd_xreq_t req [NSLV],
    output logic [NSLV-1:0] ack,
    output logic [NSLV-1:0][31:0] dat
);
    logic [31:0] mem [NSLV][16];
    logic [NSLV-1:0] wt_q = '0;
    initial ack = '0;
    initial dat = '0;
    always @(posedge clk)
    begin
        for (int p = 0; p < NSLV; p++)
        begin
            ack[p] <= 1'b0;
            // Data is junk outside an answer
            dat[p] <= ~dat[p];
            wt_q[p] <= req[p].cyc && !ack[p];
            if (req[p].cyc && !ack[p] && (wt_q[p] || !slow))
            begin
                ack[p] <= 1'b1;
                if (req[p].we)
                    mem[p][req[p].adr[5:2]] <= req[p].dat;
                else
                    dat[p] <= mem[p][req[p].adr[5:2]];
            end
        end
    end
endmodule // dpd_slave_model
